//--- rtl/pds_pkg.sv
// Shared constants and types of the process data signal block.
// Assumes one 10 MHz clock and an active low asynchronous reset.
package pds_pkg;

    // Host side interface selection
    typedef enum logic [1:0] {
        PDS_MODE_DIO = 2'b00,
        PDS_MODE_SPI = 2'b01,
        PDS_MODE_UC  = 2'b10
    } pds_mode_e;

    // Microcontroller access sequencer
    typedef enum logic [1:0] {
        PDS_UC_IDLE = 2'b00,
        PDS_UC_WAIT = 2'b01,
        PDS_UC_HOLD = 2'b10
    } pds_uc_state_e;

    // Digital I/O lanes
    localparam int DIO_LANES = 4;
    localparam int LANE_W = 8;
    localparam int DIO_W = DIO_LANES * LANE_W;

    // Control register carrying the status mirror bit
    localparam logic [15:0] CTRL_REG_ADDR = 16'h0140;
    localparam int MIRROR_BIT = 8;
    localparam int CTRL_W = 16;

    // Serial slave framing
    localparam int SPI_BITS = 8;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;

    // Microcontroller bus
    localparam int UC_ADDR_W = 16;
    localparam int UC_BE_W = 2;

    // Reset values
    localparam logic WD_STATE_RST = 1'b0;
    localparam logic [7:0] LANE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

endpackage

//--- rtl/pds_top.sv
// Process data signal block: frame and watchdog indications, general
// purpose I/O, and the digital I/O, serial slave and microcontroller ends.
// Assumes all pins and core strobes are synchronous to clk_i.
// Function
// - A core frame start pulse raises the frame start output high.
// - A core frame end pulse raises the frame end output high.
// - A core watchdog trigger drives the watchdog trigger output high.
// - The watchdog state output is low when expired or in reset and high otherwise.
// - General purpose vectors are eight bits per byte, 1, 2, 4 or 8 bytes.
// - Four eight-bit lanes are each either a driven output or an input.
// - Input lanes latch on the rising edge of the external strobe.
// - Any output lane gives an output valid pulse and takes an external enable.
// - In serial and host modes the mirror select input sets bit 8 of control register 0x0140.
// - The serial slave drives MISO directly or as data plus enable.
// - External bus drivers get split data buses and a data enable.
module pds_top #(
    parameter pds_pkg::pds_mode_e MODE = pds_pkg::PDS_MODE_DIO,
    parameter int GP_BYTES = 1,
    parameter logic [3:0] DIO_OUT_MASK = 4'h3,
    parameter bit DIO_LATCH_EXT = 1'b1,
    parameter bit EXT_DRIVERS = 1'b1,
    parameter int UC_DATA_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Core indications
    input wire logic core_sof_i,
    input wire logic core_eof_i,
    input wire logic core_wd_trigger_i,
    input wire logic core_wd_expired_i,
    input wire logic core_irq_i,
    output logic frame_start_flag_o,
    output logic frame_end_flag_o,
    output logic watchdog_trigger_out_o,
    output logic watchdog_state_out_o,
    // General purpose I/O
    input wire logic [8*GP_BYTES-1:0] gp_inputs_i,
    input wire logic [8*GP_BYTES-1:0] core_gp_out_i,
    output logic [8*GP_BYTES-1:0] gp_outputs_o,
    output logic [8*GP_BYTES-1:0] core_gp_in_o,
    // Digital I/O pins
    input wire logic [7:0] dio_in_lane0_i,
    input wire logic [7:0] dio_in_lane1_i,
    input wire logic [7:0] dio_in_lane2_i,
    input wire logic [7:0] dio_in_lane3_i,
    input wire logic dio_input_latch_strobe_i,
    input wire logic dio_external_oe_i,
    output logic [7:0] dio_out_lane0_o,
    output logic [7:0] dio_out_lane1_o,
    output logic [7:0] dio_out_lane2_o,
    output logic [7:0] dio_out_lane3_o,
    output logic dio_output_enable_o,
    output logic dio_output_valid_event_o,
    // Digital I/O core side
    input wire logic core_dio_update_i,
    input wire logic [pds_pkg::DIO_W-1:0] core_dio_out_i,
    output logic [pds_pkg::DIO_W-1:0] core_dio_in_o,
    // Status mirror
    input wire logic status_mirror_select_i,
    input wire logic [15:0] core_ctrl_i,
    input wire logic [15:0] core_host_status_i,
    output logic [15:0] ctrl_reg_value_o,
    output logic [15:0] dev_status_o,
    // Serial slave pins
    input wire logic spi_clk_i,
    input wire logic spi_select_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_direct_o,
    output logic spi_miso_data_o,
    output logic spi_miso_drive_enable_o,
    output logic spi_irq_out_o,
    // Serial slave core side
    input wire logic [7:0] core_spi_tx_i,
    output logic [7:0] core_spi_rx_o,
    output logic core_spi_rx_valid_o,
    // Microcontroller pins
    input wire logic [15:0] host_address_i,
    input wire logic host_byte_high_enable_n_i,
    input wire logic host_select_n_i,
    input wire logic host_read_n_i,
    input wire logic host_write_n_i,
    input wire logic [UC_DATA_W-1:0] host_data_inbound_i,
    output logic [UC_DATA_W-1:0] host_data_outbound_o,
    output logic host_data_drive_enable_o,
    output logic host_busy_out_o,
    output logic host_irq_out_o,
    // Microcontroller core side
    input wire logic core_uc_ack_i,
    input wire logic [UC_DATA_W-1:0] core_uc_rdata_i,
    output logic core_uc_req_o,
    output logic core_uc_write_o,
    output logic [15:0] core_uc_addr_o,
    output logic [1:0] core_uc_be_o,
    output logic [UC_DATA_W-1:0] core_uc_wdata_o
);
    localparam bit IS_SPI = (MODE == pds_pkg::PDS_MODE_SPI);
    localparam bit IS_UC = (MODE == pds_pkg::PDS_MODE_UC);
    localparam bit IS_DIO = (MODE == pds_pkg::PDS_MODE_DIO);
    localparam bit GP_ON = (GP_BYTES != 0);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_start_flag_o <= 1'b0;
            frame_end_flag_o <= 1'b0;
            watchdog_trigger_out_o <= 1'b0;
            watchdog_state_out_o <= pds_pkg::WD_STATE_RST;
        end else begin
            frame_start_flag_o <= core_sof_i;
            frame_end_flag_o <= core_eof_i;
            watchdog_trigger_out_o <= core_wd_trigger_i;
            watchdog_state_out_o <= ~core_wd_expired_i;
        end
    end
    AST_SOF: assert property (core_sof_i |=> frame_start_flag_o)
        else $error("frame start not raised");
    AST_EOF: assert property (core_eof_i |=> frame_end_flag_o)
        else $error("frame end not raised");
    // The first edge after reset is not checked, its past sample was taken in reset
    AST_WD_TRIG: assert property ($past(rst_b_i) |->
        watchdog_trigger_out_o == $past(core_wd_trigger_i))
        else $error("watchdog trigger mismatch");
    AST_WD_STATE: assert property (
        core_wd_expired_i |=> !watchdog_state_out_o)
        else $error("watchdog state high while expired");

    // general purpose vectors, held zero when no bytes configured
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gp_outputs_o <= '0;
            core_gp_in_o <= '0;
        end else begin
            gp_outputs_o <= GP_ON ? core_gp_out_i : '0;
            core_gp_in_o <= GP_ON ? gp_inputs_i : '0;
        end
    end
    AST_GP: assert property ($past(rst_b_i) |->
        gp_outputs_o == $past(core_gp_out_i))
        else $error("gp outputs do not follow core");

    // Digital I/O lane gathering
    logic [7:0] din [pds_pkg::DIO_LANES];
    logic [7:0] dout_reg [pds_pkg::DIO_LANES];
    logic strobe_prev_reg;
    logic latch_now;
    assign din[0] = dio_in_lane0_i;
    assign din[1] = dio_in_lane1_i;
    assign din[2] = dio_in_lane2_i;
    assign din[3] = dio_in_lane3_i;
    assign dio_out_lane0_o = dout_reg[0];
    assign dio_out_lane1_o = dout_reg[1];
    assign dio_out_lane2_o = dout_reg[2];
    assign dio_out_lane3_o = dout_reg[3];
    // strobe edge, or free sampling when not in latch mode
    assign latch_now = DIO_LATCH_EXT ?
        (dio_input_latch_strobe_i & ~strobe_prev_reg) : 1'b1;

    // output lanes loaded by core, input lanes never driven
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < pds_pkg::DIO_LANES; i++) begin
                dout_reg[i] <= pds_pkg::LANE_RST;
            end
        end else if (core_dio_update_i && IS_DIO) begin
            for (int i = 0; i < pds_pkg::DIO_LANES; i++) begin
                if (DIO_OUT_MASK[i]) begin
                    dout_reg[i] <= core_dio_out_i[i*8 +: 8];
                end
            end
        end
    end

    // input capture for lanes configured as inputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strobe_prev_reg <= 1'b0;
            core_dio_in_o <= '0;
        end else begin
            strobe_prev_reg <= dio_input_latch_strobe_i;
            for (int i = 0; i < pds_pkg::DIO_LANES; i++) begin
                if (!DIO_OUT_MASK[i] && latch_now && IS_DIO) begin
                    core_dio_in_o[i*8 +: 8] <= din[i];
                end
            end
        end
    end

    // output valid pulse and external enable passthrough
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dio_output_valid_event_o <= 1'b0;
            dio_output_enable_o <= 1'b0;
        end else begin
            dio_output_valid_event_o <= core_dio_update_i & IS_DIO &
                (|DIO_OUT_MASK);
            dio_output_enable_o <= dio_external_oe_i & IS_DIO &
                (|DIO_OUT_MASK);
        end
    end
    AST_DIO_IN_LANE: assert property (
        !DIO_OUT_MASK[3] |-> dio_out_lane3_o == pds_pkg::LANE_RST)
        else $error("input lane is driven");
    AST_LATCH: assert property (
        (IS_DIO && DIO_LATCH_EXT && !DIO_OUT_MASK[3] &&
         $rose(dio_input_latch_strobe_i)) |=>
        core_dio_in_o[31:24] == $past(dio_in_lane3_i))
        else $error("input not latched on strobe edge");
    AST_OUTVALID: assert property (
        (IS_DIO && |DIO_OUT_MASK && core_dio_update_i &&
         !$past(core_dio_update_i)) |=>
        dio_output_valid_event_o ##0 !$past(dio_output_valid_event_o))
        else $error("output valid pulse missing");

    // mirror bit into the control word and status selection
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg_value_o <= pds_pkg::WORD_RST;
            dev_status_o <= pds_pkg::WORD_RST;
        end else begin
            ctrl_reg_value_o <= core_ctrl_i;
            ctrl_reg_value_o[pds_pkg::MIRROR_BIT] <=
                status_mirror_select_i & ~IS_DIO;
            dev_status_o <= (status_mirror_select_i && !IS_DIO) ?
                core_ctrl_i : core_host_status_i;
        end
    end
    AST_MIRROR: assert property (
        (!IS_DIO && status_mirror_select_i) |=>
        ctrl_reg_value_o[pds_pkg::MIRROR_BIT] &&
        dev_status_o == $past(core_ctrl_i))
        else $error("status mirror not applied");

    // serial slave, mode 0: sample on rise, shift out on fall
    logic sclk_prev_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] bit_cnt_reg;
    logic sel;
    assign sel = IS_SPI & ~spi_select_n_i;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_prev_reg <= 1'b0;
            rx_sh_reg <= pds_pkg::LANE_RST;
            tx_sh_reg <= pds_pkg::LANE_RST;
            bit_cnt_reg <= 3'h0;
            core_spi_rx_o <= pds_pkg::LANE_RST;
            core_spi_rx_valid_o <= 1'b0;
        end else begin
            sclk_prev_reg <= spi_clk_i;
            core_spi_rx_valid_o <= 1'b0;
            if (!sel) begin
                bit_cnt_reg <= 3'h0;
                tx_sh_reg <= core_spi_tx_i;
            end else if (spi_clk_i && !sclk_prev_reg) begin
                rx_sh_reg <= {rx_sh_reg[6:0], spi_mosi_i};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == pds_pkg::SPI_LAST_BIT) begin
                    core_spi_rx_o <= {rx_sh_reg[6:0], spi_mosi_i};
                    core_spi_rx_valid_o <= 1'b1;
                end
            end else if (!spi_clk_i && sclk_prev_reg) begin
                // Reload after the last bit so the next byte is ready
                tx_sh_reg <= (bit_cnt_reg == 3'h0) ? core_spi_tx_i :
                    {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // MISO either direct or as data plus driver enable
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_miso_direct_o <= 1'b0;
            spi_miso_data_o <= 1'b0;
            spi_miso_drive_enable_o <= 1'b0;
            spi_irq_out_o <= 1'b0;
        end else begin
            spi_miso_direct_o <= ~EXT_DRIVERS & sel & tx_sh_reg[7];
            spi_miso_data_o <= EXT_DRIVERS & tx_sh_reg[7];
            spi_miso_drive_enable_o <= EXT_DRIVERS & sel;
            spi_irq_out_o <= IS_SPI & core_irq_i;
        end
    end
    AST_SPI_ENA: assert property (
        (IS_SPI && EXT_DRIVERS) |-> ##1
        spi_miso_drive_enable_o == !$past(spi_select_n_i))
        else $error("miso enable does not follow select");
    AST_SPI_IRQ: assert property (
        (IS_SPI && core_irq_i) |=> spi_irq_out_o)
        else $error("serial interrupt not raised");

    // host strobes start an access; busy holds until core answers
    pds_pkg::pds_uc_state_e uc_state_reg;
    logic uc_strobe;
    assign uc_strobe = IS_UC & ~host_select_n_i &
        (~host_read_n_i | ~host_write_n_i);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uc_state_reg <= pds_pkg::PDS_UC_IDLE;
            core_uc_req_o <= 1'b0;
            core_uc_write_o <= 1'b0;
            core_uc_addr_o <= pds_pkg::WORD_RST;
            core_uc_be_o <= 2'h0;
            core_uc_wdata_o <= '0;
            host_data_outbound_o <= '0;
            host_busy_out_o <= 1'b0;
        end else begin
            core_uc_req_o <= 1'b0;
            case (uc_state_reg)
                pds_pkg::PDS_UC_IDLE: begin
                    if (uc_strobe) begin
                        core_uc_req_o <= 1'b1;
                        core_uc_write_o <= ~host_write_n_i;
                        core_uc_addr_o <= host_address_i;
                        core_uc_be_o <= {~host_byte_high_enable_n_i &
                            (UC_DATA_W > 8), ~host_address_i[0]};
                        core_uc_wdata_o <= host_data_inbound_i;
                        host_busy_out_o <= 1'b1;
                        uc_state_reg <= pds_pkg::PDS_UC_WAIT;
                    end
                end
                pds_pkg::PDS_UC_WAIT: begin
                    if (core_uc_ack_i) begin
                        host_data_outbound_o <= core_uc_rdata_i;
                        host_busy_out_o <= 1'b0;
                        uc_state_reg <= pds_pkg::PDS_UC_HOLD;
                    end
                end
                pds_pkg::PDS_UC_HOLD: begin
                    // Wait for strobe release so one access is one request
                    if (!uc_strobe) begin
                        uc_state_reg <= pds_pkg::PDS_UC_IDLE;
                    end
                end
                default: begin
                    uc_state_reg <= pds_pkg::PDS_UC_IDLE;
                end
            endcase
        end
    end

    // outbound driver enabled only for a finished read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_data_drive_enable_o <= 1'b0;
            host_irq_out_o <= 1'b0;
        end else begin
            host_data_drive_enable_o <= EXT_DRIVERS & IS_UC &
                ~host_select_n_i & ~host_read_n_i & ~core_uc_write_o &
                (uc_state_reg == pds_pkg::PDS_UC_WAIT ? core_uc_ack_i :
                 uc_state_reg == pds_pkg::PDS_UC_HOLD);
            host_irq_out_o <= IS_UC & core_irq_i;
        end
    end
    AST_UC_ENA: assert property (
        host_data_drive_enable_o |-> !host_busy_out_o &&
        uc_state_reg == pds_pkg::PDS_UC_HOLD)
        else $error("data driven while access unfinished");
    AST_UC_BUSY: assert property (
        (uc_state_reg == pds_pkg::PDS_UC_IDLE && uc_strobe) |=>
        host_busy_out_o && core_uc_req_o ##1 !core_uc_req_o)
        else $error("access not taken with busy");

endmodule // pds_top

//--- sim/pds_dio_partner.sv
// Behavioural stand-in for the external digital I/O logic.
// Assumes the bench clock and reset; it drives on the falling edge.
module pds_dio_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Pacing chosen by the bench
    input wire logic [3:0] strobe_half_i,
    input wire logic oe_req_i,
    // Toward the device
    output logic [31:0] in_lanes_o,
    output logic latch_strobe_o,
    output logic ext_oe_o,
    // From the device
    input wire logic [15:0] out_lanes_i,
    input wire logic valid_event_i,
    output logic [15:0] seen_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pat;
    logic [3:0] run;

    // Inputs change every cycle so a missed latch edge is visible
    assign in_lanes_o = {pat, ~pat, pat ^ 8'hA5, pat + 8'h11};

    always @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pat <= 8'h00;
            run <= 4'h0;
            latch_strobe_o <= 1'b0;
            ext_oe_o <= 1'b0;
        end else begin
            pat <= pat + 8'h3B;
            ext_oe_o <= oe_req_i;
            run <= (run + 4'h1 >= strobe_half_i) ? 4'h0 : run + 4'h1;
            if (run + 4'h1 >= strobe_half_i) begin
                latch_strobe_o <= ~latch_strobe_o;
            end
        end
    end

    // take lanes on the valid event
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_o <= 16'h0000;
        end else if (valid_event_i) begin
            seen_o <= out_lanes_i;
        end
    end
endmodule // pds_dio_partner

//--- sim/tb_pds_top.sv
// Self-checking bench for the process data signal block in I/O mode,
// with serial and host mode copies on the same stimulus.
// Assumes lanes 0 and 1 are outputs, lanes 2 and 3 latch on a strobe.
module tb_pds_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_b, sof, eof, wdt, wdx, irq, upd, mir, oe_req;
    logic sclk, ssel_n, mosi, bhe_n, ucs_n, urd_n, uwr_n, uack, stb, xoe;
    logic o_sof, o_eof, o_wdt, o_wds, o_ena, o_vld;
    logic [15:0] gpi, gpc, ctrl, hst, uadr, udin, urdat, o_gpo, o_gpi;
    logic [15:0] o_ctrl, seen, o_dst, m_ctl1, m_dst1, m_dst0;
    logic [15:0] a_ctrl [1:2];
    logic [15:0] a_dst [1:2];
    logic a_sirq [1:2];
    logic a_hirq [1:2];
    logic m_irq;
    logic [7:0] stx, l0, l1, l2, l3;
    logic [31:0] dout, o_din, pin;
    logic [3:0] half;
    logic [5:0] m_f;
    logic [15:0] m_go, m_gi, m_ctrl, m_seen, m_in;
    logic [31:0] m_lanes;
    logic m_stb;
    integer seed = 32'he463;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int ph, i;

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    pds_top #(.MODE(pds_pkg::PDS_MODE_DIO), .GP_BYTES(2),
        .DIO_OUT_MASK(4'h3), .DIO_LATCH_EXT(1'b1), .EXT_DRIVERS(1'b1),
        .UC_DATA_W(16)) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b), .core_sof_i(sof), .core_eof_i(eof),
        .core_wd_trigger_i(wdt), .core_wd_expired_i(wdx), .core_irq_i(irq),
        .frame_start_flag_o(o_sof), .frame_end_flag_o(o_eof),
        .watchdog_trigger_out_o(o_wdt), .watchdog_state_out_o(o_wds),
        .gp_inputs_i(gpi), .core_gp_out_i(gpc), .gp_outputs_o(o_gpo),
        .core_gp_in_o(o_gpi), .dio_in_lane0_i(pin[7:0]),
        .dio_in_lane1_i(pin[15:8]), .dio_in_lane2_i(pin[23:16]),
        .dio_in_lane3_i(pin[31:24]), .dio_input_latch_strobe_i(stb),
        .dio_external_oe_i(xoe), .dio_out_lane0_o(l0), .dio_out_lane1_o(l1),
        .dio_out_lane2_o(l2), .dio_out_lane3_o(l3),
        .dio_output_enable_o(o_ena), .dio_output_valid_event_o(o_vld),
        .core_dio_update_i(upd), .core_dio_out_i(dout),
        .core_dio_in_o(o_din), .status_mirror_select_i(mir),
        .core_ctrl_i(ctrl), .core_host_status_i(hst),
        .ctrl_reg_value_o(o_ctrl), .dev_status_o(o_dst), .spi_clk_i(sclk),
        .spi_select_n_i(ssel_n), .spi_mosi_i(mosi), .spi_miso_direct_o(),
        .spi_miso_data_o(), .spi_miso_drive_enable_o(), .spi_irq_out_o(),
        .core_spi_tx_i(stx), .core_spi_rx_o(), .core_spi_rx_valid_o(),
        .host_address_i(uadr), .host_byte_high_enable_n_i(bhe_n),
        .host_select_n_i(ucs_n), .host_read_n_i(urd_n),
        .host_write_n_i(uwr_n), .host_data_inbound_i(udin),
        .host_data_outbound_o(), .host_data_drive_enable_o(),
        .host_busy_out_o(), .host_irq_out_o(), .core_uc_ack_i(uack),
        .core_uc_rdata_i(urdat), .core_uc_req_o(), .core_uc_write_o(),
        .core_uc_addr_o(), .core_uc_be_o(), .core_uc_wdata_o());

    pds_dio_partner u_io (.clk_i(clk_i), .rst_b_i(rst_b),
        .strobe_half_i(half), .oe_req_i(oe_req), .in_lanes_o(pin),
        .latch_strobe_o(stb), .ext_oe_o(xoe), .out_lanes_i({l1, l0}),
        .valid_event_i(o_vld), .seen_o(seen));

    // Serial and host modes, so the mode-only rules are exercised too
    for (genvar g = 1; g < 3; g++) begin : g_alt
        pds_top #(.MODE(g == 1 ? pds_pkg::PDS_MODE_SPI :
            pds_pkg::PDS_MODE_UC), .GP_BYTES(2), .DIO_OUT_MASK(4'h3),
            .DIO_LATCH_EXT(1'b1), .EXT_DRIVERS(1'b1), .UC_DATA_W(16)) u_alt (
            .clk_i(clk_i), .rst_b_i(rst_b), .core_sof_i(sof),
            .core_eof_i(eof), .core_wd_trigger_i(wdt),
            .core_wd_expired_i(wdx), .core_irq_i(irq),
            .frame_start_flag_o(), .frame_end_flag_o(),
            .watchdog_trigger_out_o(), .watchdog_state_out_o(),
            .gp_inputs_i(gpi), .core_gp_out_i(gpc), .gp_outputs_o(),
            .core_gp_in_o(), .dio_in_lane0_i(pin[7:0]),
            .dio_in_lane1_i(pin[15:8]), .dio_in_lane2_i(pin[23:16]),
            .dio_in_lane3_i(pin[31:24]), .dio_input_latch_strobe_i(stb),
            .dio_external_oe_i(xoe), .dio_out_lane0_o(),
            .dio_out_lane1_o(), .dio_out_lane2_o(), .dio_out_lane3_o(),
            .dio_output_enable_o(), .dio_output_valid_event_o(),
            .core_dio_update_i(upd), .core_dio_out_i(dout),
            .core_dio_in_o(), .status_mirror_select_i(mir),
            .core_ctrl_i(ctrl), .core_host_status_i(hst),
            .ctrl_reg_value_o(a_ctrl[g]), .dev_status_o(a_dst[g]),
            .spi_clk_i(sclk), .spi_select_n_i(ssel_n), .spi_mosi_i(mosi),
            .spi_miso_direct_o(), .spi_miso_data_o(),
            .spi_miso_drive_enable_o(), .spi_irq_out_o(a_sirq[g]),
            .core_spi_tx_i(stx), .core_spi_rx_o(), .core_spi_rx_valid_o(),
            .host_address_i(uadr), .host_byte_high_enable_n_i(bhe_n),
            .host_select_n_i(ucs_n), .host_read_n_i(urd_n),
            .host_write_n_i(uwr_n), .host_data_inbound_i(udin),
            .host_data_outbound_o(), .host_data_drive_enable_o(),
            .host_busy_out_o(), .host_irq_out_o(a_hirq[g]),
            .core_uc_ack_i(uack), .core_uc_rdata_i(urdat),
            .core_uc_req_o(), .core_uc_write_o(), .core_uc_addr_o(),
            .core_uc_be_o(), .core_uc_wdata_o());
    end

    // Reference model, one clock behind its inputs like the design
    always @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            {m_f, m_go, m_gi, m_ctrl, m_seen, m_in, m_lanes, m_stb} <= '0;
            {m_ctl1, m_dst1, m_dst0, m_irq} <= '0;
        end else begin
            m_f <= {sof, eof, wdt, !wdx, upd, xoe};
            m_go <= gpc;
            m_gi <= gpi;
            m_ctrl <= ctrl & 16'hFEFF;
            // Outside I/O mode bit 8 carries the mirror select
            m_ctl1 <= {ctrl[15:9], mir, ctrl[7:0]};
            m_dst1 <= mir ? ctrl : hst;
            m_dst0 <= hst;
            m_irq <= irq;
            m_stb <= stb;
            if (upd) m_lanes <= {16'h0000, dout[15:0]};
            if (stb && !m_stb) m_in <= pin[31:16];
            if (m_f[1]) m_seen <= m_lanes[15:0];
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_all();
        chk("frame_start", 32'(m_f[5]), 32'(o_sof));
        chk("frame_end", 32'(m_f[4]), 32'(o_eof));
        chk("wd_trigger", 32'(m_f[3]), 32'(o_wdt));
        chk("wd_state", 32'(m_f[2]), 32'(o_wds));
        chk("gp_outputs", 32'(m_go), 32'(o_gpo));
        chk("gp_inputs", 32'(m_gi), 32'(o_gpi));
        chk("out_lanes", m_lanes, {l3, l2, l1, l0});
        chk("in_lanes", 32'(m_in), 32'(o_din[31:16]));
        chk("out_valid", 32'(m_f[1]), 32'(o_vld));
        chk("out_enable", 32'(m_f[0]), 32'(o_ena));
        chk("partner_seen", 32'(m_seen), 32'(seen));
        chk("ctrl_reg", 32'(m_ctrl), 32'(o_ctrl));
        chk("dev_status", 32'(m_dst0), 32'(o_dst));
        for (int g = 1; g < 3; g++) begin
            chk("alt_ctrl_reg", 32'(m_ctl1), 32'(a_ctrl[g]));
            chk("alt_status", 32'(m_dst1), 32'(a_dst[g]));
            chk("spi_irq", 32'(g == 1 && m_irq), 32'(a_sirq[g]));
            chk("host_irq", 32'(g == 2 && m_irq), 32'(a_hirq[g]));
        end
    endtask

    // Random stimulus, also on the pins this mode must ignore
    task automatic drive(input bit every);
        {sof, eof, wdt, wdx, irq, mir, bhe_n, ucs_n} = 8'($random(seed));
        {urd_n, uwr_n, sclk, ssel_n, mosi, uack, oe_req} = 7'($random(seed));
        upd = every ? 1'b1 : (2'($random(seed)) == 2'h0);
        dout = $random(seed);
        {gpi, gpc} = $random(seed);
        {ctrl, hst} = $random(seed);
        {uadr, udin} = $random(seed);
        {urdat, stx} = 24'($random(seed));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 620 cycles of the run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            end_sim();
        end
    end

    // Sparse, back-to-back, slow strobe, then a reset in mid-run
    initial begin
        rst_b = 1'b0;
        half = 4'h1;
        drive(1'b0);
        repeat (16) @(negedge clk_i);
        rst_b = 1'b1;
        for (ph = 0; ph < 4; ph++) begin
            half = (ph == 2) ? 4'h5 : 4'h1;
            for (i = 0; i < 150; i++) begin
                @(negedge clk_i);
                check_all();
                drive(ph == 1);
                if (ph == 3 && i == 40) rst_b = 1'b0;
                if (ph == 3 && i == 44) rst_b = 1'b1;
            end
        end
        end_sim();
    end
endmodule // tb_pds_top
